// [eec_pkg.sv]
package eec_pkg;

  // ----------------------------------------------------------------
  // Clock and pin widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TMR_W = 18;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Pin timing, in nanoseconds
  // ----------------------------------------------------------------
  localparam int unsigned T_SETUP_NS = 50;
  localparam int unsigned T_RD_REC_NS = 2000;
  localparam int unsigned T_ACC_NS = 200;
  localparam int unsigned T_CHIP_SETUP_NS = 1000;
  localparam int unsigned T_OE_HOLD_NS = 1000;
  localparam int unsigned T_ERASE_REC_NS = 10000;
  localparam int unsigned T_WP_STD_NS = 9000000;
  localparam int unsigned T_WP_FAST_NS = 1000000;
  localparam int unsigned T_WP_CHIP_NS = 10000000;

  // Least time to whole cycles, never below one
  function automatic int unsigned eec_cyc_up(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned SETUP_CYC = eec_cyc_up(T_SETUP_NS);
  localparam int unsigned RD_REC_CYC = eec_cyc_up(T_RD_REC_NS);
  localparam int unsigned ACC_CYC = eec_cyc_up(T_ACC_NS) + SYNC_STAGES;
  localparam int unsigned CHIP_SETUP_CYC = eec_cyc_up(T_CHIP_SETUP_NS);
  localparam int unsigned OE_HOLD_CYC = eec_cyc_up(T_OE_HOLD_NS);
  localparam int unsigned ERASE_REC_CYC = eec_cyc_up(T_ERASE_REC_NS);

  // Data pattern of an erase
  localparam logic [DATA_W-1:0] ERASE_DATA = 8'hff;

  // ----------------------------------------------------------------
  // Commands and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_ERASE = 2'h2,
    OP_CHIP = 2'h3
  } eec_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_PULSE = 3'h2,
    ST_OEHOLD = 3'h3,
    ST_RECOV = 3'h4,
    ST_READ = 3'h5
  } eec_state_t;

endpackage

// [eec_timer.sv]
module eec_timer #(
  parameter int unsigned W = 18
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic expired_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Reload or count down to zero
  assign nxt_cnt = load_i ? load_val_i : ((cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff);
  assign expired_o = (cnt_ff == '0);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  load_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
    load_i |=> (cnt_ff == $past(load_val_i)))
    else $error("timer did not take the loaded count");

endmodule

// [eec_host.sv]
// Behaviour
// R1: Device decodes six modes from strobes
// R2: Host erases a byte before writing it
// R3: Erase: select low, gate high, data ones
// R4: Device latches inputs on strobe fall
// R5: Device byte erase ends under 10 ms
// R6: Write equals erase but with true data
// R7: Fast variant erases or writes in 1 ms
// R8: Device accepts low or high-voltage strobe
// R9: Device ignores write-strobe rising edge timing
// R10: Chip erase holds gate at high voltage
// R11: Device alters only the addressed byte
// R12: Read: strobe high, select and gate low
// R13: Select high gives standby, data floats
// R14: Device blocks writes at low supply
// R15: Device refuses writes with wrong select/gate
// R16: Inputs ignored from hold until recovery
// R17: Strobe low at least 9 ms or 1 ms
// R18: Device timer rejects requests while busy
module eec_host
  import eec_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b0,
  parameter int unsigned WP_CYC =
    eec_pkg::eec_cyc_up(FAST_VARIANT ? eec_pkg::T_WP_FAST_NS : eec_pkg::T_WP_STD_NS),
  parameter int unsigned CHIP_WP_CYC = eec_pkg::eec_cyc_up(eec_pkg::T_WP_CHIP_NS)
)(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic REQ_VALID_I,
  input wire logic [1:0] REQ_OP_I,
  input wire logic [eec_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [eec_pkg::DATA_W-1:0] REQ_WDATA_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  output logic [eec_pkg::DATA_W-1:0] RDATA_O,
  output logic CE_N_O,
  output logic OE_N_O,
  output logic OE_HV_O,
  output logic WE_N_O,
  output logic [eec_pkg::ADDR_W-1:0] ADDR_O,
  output logic [eec_pkg::DATA_W-1:0] DQ_O,
  output logic DQ_OE_O,
  input wire logic [eec_pkg::DATA_W-1:0] DQ_I
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  eec_state_t state_ff, nxt_state;
  eec_op_t op_ff, nxt_op;
  logic erase_phase_ff, nxt_erase_phase;
  logic ce_n_ff, nxt_ce_n;
  logic oe_n_ff, nxt_oe_n;
  logic hv_ff, nxt_hv;
  logic we_n_ff, nxt_we_n;
  logic dq_oe_ff, nxt_dq_oe;
  logic ready_ff, nxt_ready;
  logic done_ff, nxt_done;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [DATA_W-1:0] dq_ff, nxt_dq;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [DATA_W-1:0] sync1_ff, sync2_ff;
  logic tmr_ld;
  logic [TMR_W-1:0] tmr_val;
  wire tmr_exp;

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  wire accept = ready_ff && REQ_VALID_I;
  wire req_read = (REQ_OP_I == OP_READ);
  wire req_chip = (REQ_OP_I == OP_CHIP);
  wire is_chip = (op_ff == OP_CHIP);
  wire [TMR_W-1:0] setup_len = is_chip ? TMR_W'(CHIP_SETUP_CYC) : TMR_W'(SETUP_CYC);
  wire [TMR_W-1:0] pulse_len = is_chip ? TMR_W'(CHIP_WP_CYC) : TMR_W'(WP_CYC);
  wire [TMR_W-1:0] req_setup_len = req_chip ? TMR_W'(CHIP_SETUP_CYC) : TMR_W'(SETUP_CYC);

  // Interval timer
  eec_timer #(
    .W(TMR_W)
  ) u_timer (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .load_i(tmr_ld),
    .load_val_i(tmr_val),
    .expired_o(tmr_exp)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_erase_phase = erase_phase_ff;
    nxt_ce_n = ce_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_hv = hv_ff;
    nxt_we_n = we_n_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_ready = ready_ff;
    nxt_done = 1'b0;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_dq = dq_ff;
    nxt_rdata = rdata_ff;
    tmr_ld = 1'b0;
    tmr_val = '0;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (accept)
        begin
          nxt_op = eec_op_t'(REQ_OP_I);
          nxt_addr = REQ_ADDR_I;
          nxt_wdata = REQ_WDATA_I;
          nxt_ready = 1'b0;
          nxt_ce_n = 1'b0;
          tmr_ld = 1'b1;
          if (req_read)
          begin
            nxt_oe_n = 1'b0; // R12
            nxt_state = ST_READ;
            tmr_val = TMR_W'(ACC_CYC);
          end
          else
          begin
            nxt_oe_n = 1'b1; // R3
            nxt_hv = req_chip; // R10
            nxt_dq_oe = 1'b1;
            nxt_dq = ERASE_DATA; // R3
            nxt_erase_phase = (REQ_OP_I == OP_WRITE); // R2
            nxt_state = ST_SETUP;
            tmr_val = req_setup_len;
          end
        end
      end
      ST_SETUP:
      begin
        if (tmr_exp)
        begin
          nxt_we_n = 1'b0;
          nxt_state = ST_PULSE;
          tmr_ld = 1'b1;
          tmr_val = pulse_len; // R17
        end
      end
      ST_PULSE:
      begin
        if (tmr_exp)
        begin
          nxt_we_n = 1'b1;
          tmr_ld = 1'b1;
          nxt_state = is_chip ? ST_OEHOLD : ST_RECOV;
          tmr_val = is_chip ? TMR_W'(OE_HOLD_CYC) : TMR_W'(RD_REC_CYC);
        end
      end
      ST_OEHOLD:
      begin
        if (tmr_exp)
        begin
          nxt_hv = 1'b0; // R10
          nxt_state = ST_RECOV;
          tmr_ld = 1'b1;
          tmr_val = TMR_W'(ERASE_REC_CYC);
        end
      end
      ST_RECOV:
      begin
        if (tmr_exp && erase_phase_ff)
        begin
          nxt_erase_phase = 1'b0; // R2
          nxt_dq = wdata_ff; // R6
          nxt_state = ST_SETUP;
          tmr_ld = 1'b1;
          tmr_val = TMR_W'(SETUP_CYC);
        end
        else if (tmr_exp)
        begin
          nxt_ce_n = 1'b1; // R13
          nxt_dq_oe = 1'b0;
          nxt_done = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_READ:
      begin
        if (tmr_exp)
        begin
          nxt_rdata = sync2_ff; // R12
          nxt_oe_n = 1'b1;
          nxt_ce_n = 1'b1;
          nxt_done = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_ce_n = 1'b1;
        nxt_oe_n = 1'b1;
        nxt_we_n = 1'b1;
        nxt_hv = 1'b0;
        nxt_dq_oe = 1'b0;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_ff <= ST_IDLE;
      op_ff <= OP_READ;
      erase_phase_ff <= 1'b0;
      ce_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      hv_ff <= 1'b0;
      we_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      ready_ff <= 1'b1;
      done_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      dq_ff <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      erase_phase_ff <= nxt_erase_phase;
      ce_n_ff <= nxt_ce_n;
      oe_n_ff <= nxt_oe_n;
      hv_ff <= nxt_hv;
      we_n_ff <= nxt_we_n;
      dq_oe_ff <= nxt_dq_oe;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      dq_ff <= nxt_dq;
      rdata_ff <= nxt_rdata;
    end
  end

  // Data pins through two flops
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= DQ_I;
      sync2_ff <= sync1_ff;
    end
  end

  // Output pins straight from flops
  assign REQ_READY_O = ready_ff;
  assign DONE_O = done_ff;
  assign RDATA_O = rdata_ff;
  assign CE_N_O = ce_n_ff;
  assign OE_N_O = oe_n_ff;
  assign OE_HV_O = hv_ff;
  assign WE_N_O = we_n_ff;
  assign ADDR_O = addr_ff;
  assign DQ_O = dq_ff;
  assign DQ_OE_O = dq_oe_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] low_cnt_ff;
  logic erased_vld_ff;
  logic [ADDR_W-1:0] erased_addr_ff;
  wire [TMR_W-1:0] need_cyc = hv_ff ? TMR_W'(CHIP_WP_CYC) : TMR_W'(WP_CYC);
  wire we_fall = we_n_ff && !nxt_we_n;

  // Strobe low length and last erased byte
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      low_cnt_ff <= '0;
      erased_vld_ff <= 1'b0;
      erased_addr_ff <= '0;
    end
    else
    begin
      low_cnt_ff <= we_n_ff ? '0 : low_cnt_ff + 1'b1;
      if (we_fall && (dq_ff == ERASE_DATA))
      begin
        erased_vld_ff <= 1'b1;
        erased_addr_ff <= addr_ff;
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  erase_first_a: assert property ($fell(we_n_ff) && (dq_ff != ERASE_DATA) |-> // R2
    erased_vld_ff && (erased_addr_ff == addr_ff))
    else $error("byte written without prior erase");
  erase_levels_a: assert property ($fell(we_n_ff) |-> // R3
    !ce_n_ff && oe_n_ff && dq_oe_ff)
    else $error("strobe fell with wrong select or gate");
  write_data_a: assert property ($fell(we_n_ff) && !erase_phase_ff && (op_ff == OP_WRITE) |-> // R6
    dq_ff == wdata_ff)
    else $error("write pulse without true data");
  chip_hv_a: assert property ($fell(we_n_ff) && (op_ff == OP_CHIP) |-> // R10
    hv_ff && (dq_ff == ERASE_DATA) ##1 hv_ff)
    else $error("chip erase without high gate");
  read_levels_a: assert property (!oe_n_ff |-> // R12
    we_n_ff && !ce_n_ff && !dq_oe_ff && !hv_ff)
    else $error("read with bad strobe levels");
  standby_idle_a: assert property ((state_ff == ST_IDLE) |-> // R13
    ce_n_ff && we_n_ff && !dq_oe_ff)
    else $error("select low while idle");
  hold_stable_a: assert property (!we_n_ff && !$past(we_n_ff) |-> // R16
    $stable(addr_ff) && $stable(dq_ff) && $stable(ce_n_ff) && $stable(oe_n_ff))
    else $error("pins changed during strobe");
  pulse_width_a: assert property ($rose(we_n_ff) |-> low_cnt_ff >= need_cyc) // R17
    else $error("strobe pulse too short");

  read_done_c: cover property ((op_ff == OP_READ) && done_ff);
  write_done_c: cover property ((op_ff == OP_WRITE) && done_ff);
  chip_done_c: cover property ((op_ff == OP_CHIP) && done_ff);
  back_to_back_c: cover property (done_ff ##1 !ready_ff);

endmodule

// [eec_dev_model.sv]
module eec_dev_model
  import eec_pkg::*;
#(
  parameter int unsigned TWP_NS = 800,
  parameter int unsigned OP_NS = 500
)(
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic oe_hv_i,
  input wire logic we_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output int viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:2047];
  logic [ADDR_W-1:0] lat_a;
  logic [DATA_W-1:0] lat_d;
  logic lat_chip;
  bit busy = 0;
  bit armed = 0;
  time t_fall;

  // ----------------------------------------------------------------
  // Read and standby
  // ----------------------------------------------------------------
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    dq_o = 8'h00;
    viol_o = 0;
  end
  assign dq_oe_o = !ce_n_i && !oe_n_i && we_n_i;
  // Data after access time
  always @(posedge dq_oe_o)
  begin
    #100 dq_o = mem[addr_i];
  end
  // Released lines do not keep the last value
  always @(negedge dq_oe_o) dq_o = ~dq_o;

  // ----------------------------------------------------------------
  // Strobe fall latches inputs, starts self-timed operation
  // ----------------------------------------------------------------
  always @(negedge we_n_i)
  begin
    if (busy)
      viol_o++;
    else if (!ce_n_i && oe_n_i)
    begin
      lat_a = addr_i;
      lat_d = dq_i;
      lat_chip = oe_hv_i;
      if (!lat_chip && lat_d != 8'hff && mem[lat_a] != 8'hff) viol_o++;
      t_fall = $time;
      armed = 1;
      busy = 1;
    end
  end
  // Pulse width kept by host; rise time itself is free
  always @(posedge we_n_i)
  begin
    if (armed && ($time - t_fall) < TWP_NS) viol_o++;
    armed = 0;
  end
  // Internal timer, well under the erase limit
  always @(posedge busy)
  begin
    #(OP_NS);
    if (lat_chip)
      foreach (mem[i]) mem[i] = 8'hff;
    else
      mem[lat_a] = lat_d;
    busy = 0;
  end
endmodule

// [eec_host_test.sv]
module eec_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import eec_pkg::*;
  logic clk = 0, rst_n = 0, valid = 0;
  logic [1:0] op = 2'h0;
  logic [ADDR_W-1:0] addr = 11'h000;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic ready, done, ce_n, oe_n, oe_hv, we_n, dq_oe, dev_oe;
  logic [DATA_W-1:0] rdata, dq_out, dev_dq, dq_bus;
  logic [ADDR_W-1:0] pin_a;
  int viol, miscompares = 0, total_checks = 0;
  bit hv_seen;

  // ----------------------------------------------------------------
  // Clock, design, device
  // ----------------------------------------------------------------
  always #20 clk = ~clk;
  assign dq_bus = dq_oe ? dq_out : dev_dq;
  eec_host #(.WP_CYC(20), .CHIP_WP_CYC(30)) u_dut (.CLK_I(clk), .RESET_N_I(rst_n),
    .REQ_VALID_I(valid), .REQ_OP_I(op), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata),
    .REQ_READY_O(ready), .DONE_O(done), .RDATA_O(rdata), .CE_N_O(ce_n), .OE_N_O(oe_n),
    .OE_HV_O(oe_hv), .WE_N_O(we_n), .ADDR_O(pin_a), .DQ_O(dq_out), .DQ_OE_O(dq_oe),
    .DQ_I(dq_bus));
  eec_dev_model #(.TWP_NS(800), .OP_NS(500)) u_dev (.ce_n_i(ce_n), .oe_n_i(oe_n),
    .oe_hv_i(oe_hv), .we_n_i(we_n), .addr_i(pin_a), .dq_i(dq_bus), .dq_o(dev_dq),
    .dq_oe_o(dev_oe), .viol_o(viol));

  // ----------------------------------------------------------------
  // Compare and command tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t pin got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      miscompares++;
      $display("ERROR %0t device saw %0d faults", $time, got);
    end
  endtask
  // Issue one command; optional poke while busy
  task automatic run_cmd(input logic [1:0] c, input logic [10:0] a, input logic [7:0] d,
                         input bit poke);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    op <= c;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    valid <= poke;
    op <= 2'h2;
    addr <= a ^ 11'h001;
    hv_seen = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n == 10) valid <= 1'b0;
      #1;
      if (oe_hv === 1'b1) hv_seen = 1;
      if (dev_oe === 1'b1) chk1(dq_oe, 1'b0);
    end while (done !== 1'b1 && n < 3000);
    chk1(done, 1'b1);
    chk1(ready, 1'b1);
  endtask
  task automatic read_chk(input logic [10:0] a, input logic [7:0] exp);
    run_cmd(2'h0, a, 8'h00, 0);
    chk8(rdata, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk1(ce_n, 1'b1);
    chk1(we_n, 1'b1);
    chk1(oe_hv, 1'b0);
    chk1(dq_oe, 1'b0);
    chk1(oe_n, 1'b1);
    chk1(ready, 1'b1);
  endtask
  task automatic t_write_read();
    run_cmd(2'h1, 11'h7ff, 8'ha5, 0);
    read_chk(11'h7ff, 8'ha5);
  endtask
  task automatic t_neighbours();
    run_cmd(2'h1, 11'h005, 8'h3c, 0);
    run_cmd(2'h1, 11'h006, 8'hc3, 0);
    read_chk(11'h005, 8'h3c);
    run_cmd(2'h2, 11'h005, 8'h00, 0);
    read_chk(11'h005, 8'hff);
    read_chk(11'h006, 8'hc3);
  endtask
  task automatic t_busy_refused();
    run_cmd(2'h1, 11'h011, 8'h66, 0);
    run_cmd(2'h1, 11'h010, 8'h77, 1);
    chk1(ce_n, 1'b1);
    read_chk(11'h011, 8'h66);
    read_chk(11'h010, 8'h77);
  endtask
  task automatic t_chip();
    run_cmd(2'h3, 11'h000, 8'h00, 0);
    chk1(hv_seen, 1'b1);
    read_chk(11'h7ff, 8'hff);
    read_chk(11'h010, 8'hff);
    chk_cnt(viol, 0);
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog, verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    t_write_read();
    t_neighbours();
    t_busy_refused();
    t_chip();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
